// [hdl/pfb_pkg.sv]
// Package of constants and types for the parallel flash bus host controller
// Summary of operation
// - Read: chip select low, output enable low, write enable held high.
// - Write: chip select and write enable low, output enable held high.
// - In fast program mode one byte takes two write cycles, not four.
// - During program or erase, reads return status bits, normal read timing.
// - After standby, wait full chip-select access time before sampling data.
// - Sector protect: high reset voltage, select low, read high, write low, A6=0.
// - Sector unprotect: same levels as protect but address bit six high.
package pfb_pkg;
	localparam int ADDR_W = 21;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_NS = 50;
	// Access time of the slowest speed grade
	localparam int T_CE_NS = 120;
	localparam int T_OE_NS = 50;
	// Write enable pulse and high time
	localparam int T_WP_NS = 50;
	localparam int T_WPH_NS = 50;
	// Reset pulse width and recovery
	localparam int T_RP_NS = 500;
	localparam int T_RH_NS = 50;
	// Protect pulse width on the high-voltage path
	localparam int T_PPW_NS = 150000;
	localparam int CE_CYC = (T_CE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OE_CYC = (T_OE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RH_CYC = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PPW_CYC = (T_PPW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;
	// Address bit positions used by the protect paths
	localparam int ABIT_PROT_SEL = 6;
	localparam int ABIT_ONE = 1;
	localparam int ABIT_ZERO = 0;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RST = 21'h00_0000;
	typedef enum logic [2:0] {
		PFB_OP_READ,
		PFB_OP_WRITE,
		PFB_OP_RESET,
		PFB_OP_PROTECT,
		PFB_OP_UNPROTECT
	} pfb_op_t;
endpackage : pfb_pkg

// [hdl/pfb_sync.sv]
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pfb_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         nrst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	always_comb begin
		next_meta = d_in;
		next_q = meta;
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta <= '0;
			q_out <= '0;
		end else begin
			meta <= next_meta;
			q_out <= next_q;
		end
	end
endmodule : pfb_sync
`default_nettype wire

// [hdl/pfb_host.sv]
// Host-side controller that drives the parallel flash bus pins
`timescale 1ns/1ps
`default_nettype none
module pfb_host
	import pfb_pkg::*;
(
	input  wire logic                  clk_in,
	input  wire logic                  nrst_in,
	// User request side
	input  wire logic                  req_valid_in,
	output logic                       req_ready_out,
	input  wire pfb_pkg::pfb_op_t      req_op_in,
	input  wire logic [pfb_pkg::ADDR_W-1:0] req_addr_in,
	input  wire logic [pfb_pkg::DATA_W-1:0] req_data_in,
	output logic                       rsp_valid_out,
	output logic [pfb_pkg::DATA_W-1:0] rsp_data_out,
	output logic                       busy_out,
	// Flash pins
	output logic [pfb_pkg::ADDR_W-1:0] address_pins_out,
	input  wire logic [pfb_pkg::DATA_W-1:0] data_pins_in,
	output logic [pfb_pkg::DATA_W-1:0] data_pins_out,
	output logic                       data_pins_oe_out,
	output logic                       chip_sel_n_out,
	output logic                       out_en_n_out,
	output logic                       wr_en_n_out,
	output logic                       flash_rst_n_out,
	output logic                       high_id_voltage_out,
	input  wire logic                  ready_busy_n_in
);
	import pfb_pkg::*;

	// ========================================
	// Sequencer state
	typedef enum {
		ST_IDLE,
		ST_RD_WAIT,
		ST_WR_PULSE,
		ST_WR_HOLD,
		ST_RST_PULSE,
		ST_RST_REC,
		ST_PR_PULSE
	} pfb_state_t;

	pfb_state_t         state;
	pfb_state_t         next_state;
	logic [CNT_W-1:0]   cnt;
	logic [CNT_W-1:0]   next_cnt;
	logic [ADDR_W-1:0]  addr;
	logic [ADDR_W-1:0]  next_addr;
	logic [DATA_W-1:0]  wdata;
	logic [DATA_W-1:0]  next_wdata;
	logic [DATA_W-1:0]  rdata;
	logic [DATA_W-1:0]  next_rdata;
	logic               rvalid;
	logic               next_rvalid;
	logic               hv;
	logic               next_hv;
	// Synchronised pins; the busy pin enters inverted so that its
	// synchroniser resets to the idle, not busy, level
	logic [DATA_W-1:0]  data_sync;
	logic               rb_sync;

	// ========================================
	// Pin input synchronisers
	pfb_sync #(.W(DATA_W)) u_sync_data (
		.clk_in  (clk_in),
		.nrst_in (nrst_in),
		.d_in    (data_pins_in),
		.q_out   (data_sync)
	);

	pfb_sync #(.W(1)) u_sync_rb (
		.clk_in  (clk_in),
		.nrst_in (nrst_in),
		.d_in    (!ready_busy_n_in),
		.q_out   (rb_sync)
	);

	// ========================================
	// Sequencer
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_addr = addr;
		next_wdata = wdata;
		next_rdata = rdata;
		next_rvalid = 1'b0;
		next_hv = hv;
		case (state)
			ST_IDLE: begin
				if (req_valid_in) begin
					next_addr = req_addr_in;
					next_wdata = req_data_in;
					next_cnt = '0;
					case (req_op_in)
						PFB_OP_READ: next_state = ST_RD_WAIT;
						PFB_OP_WRITE: next_state = ST_WR_PULSE;
						PFB_OP_RESET: next_state = ST_RST_PULSE;
						PFB_OP_PROTECT: begin
							next_addr[ABIT_PROT_SEL] = 1'b0;
							next_addr[ABIT_ONE] = 1'b1;
							next_addr[ABIT_ZERO] = 1'b0;
							next_hv = 1'b1;
							next_state = ST_PR_PULSE;
						end
						PFB_OP_UNPROTECT: begin
							next_addr[ABIT_PROT_SEL] = 1'b1;
							next_addr[ABIT_ONE] = 1'b1;
							next_addr[ABIT_ZERO] = 1'b0;
							next_hv = 1'b1;
							next_state = ST_PR_PULSE;
						end
						default: next_state = ST_IDLE;
					endcase
				end
			end
			ST_RD_WAIT: begin
				// Full select access time from standby, plus the two
				// synchroniser stages, so the byte taken stood on the pins
				// no earlier than the access time after select
				if (cnt >= CNT_W'(CE_CYC + 1)) begin
					next_rdata = data_sync;
					next_rvalid = 1'b1;
					next_state = ST_IDLE;
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
			ST_WR_PULSE: begin
				if (cnt >= CNT_W'(WP_CYC - 1)) begin
					next_cnt = '0;
					next_state = ST_WR_HOLD;
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
			ST_WR_HOLD: begin
				if (cnt >= CNT_W'(WPH_CYC - 1)) begin
					next_state = ST_IDLE;
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
			ST_RST_PULSE: begin
				if (cnt >= CNT_W'(RP_CYC - 1)) begin
					next_cnt = '0;
					next_state = ST_RST_REC;
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
			ST_RST_REC: begin
				if (cnt >= CNT_W'(RH_CYC - 1)) begin
					next_state = ST_IDLE;
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
			ST_PR_PULSE: begin
				if (cnt >= CNT_W'(PPW_CYC - 1)) begin
					// High voltage drops with the end of the pulse
					next_hv = 1'b0;
					next_cnt = '0;
					next_state = ST_WR_HOLD;
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state <= ST_IDLE;
			cnt <= '0;
			addr <= ADDR_RST;
			wdata <= DATA_RST;
			rdata <= DATA_RST;
			rvalid <= 1'b0;
			hv <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			addr <= next_addr;
			wdata <= next_wdata;
			rdata <= next_rdata;
			rvalid <= next_rvalid;
			hv <= next_hv;
		end
	end

	// ========================================
	// Pin drive
	logic rd_phase;
	logic wr_phase;
	logic wr_hold;
	assign rd_phase = (state == ST_RD_WAIT);
	assign wr_phase = (state == ST_WR_PULSE) || (state == ST_PR_PULSE);
	assign wr_hold = (state == ST_WR_HOLD);

	// Strobes are exclusive: write low only when read enable high
	assign chip_sel_n_out = !(rd_phase || wr_phase);
	assign out_en_n_out = !rd_phase;
	assign wr_en_n_out = !wr_phase;
	// Reset pin is only pulsed low; the protect voltage is raised by the
	// board while the high-voltage request is set
	assign flash_rst_n_out = (state != ST_RST_PULSE);
	assign high_id_voltage_out = hv;
	// Address and write data stand for the whole phase
	assign address_pins_out = addr;
	assign data_pins_out = wdata;
	// Drive data only while the write is strobed and the hold after it
	assign data_pins_oe_out = wr_phase || wr_hold;
	assign req_ready_out = (state == ST_IDLE);
	assign rsp_valid_out = rvalid;
	assign rsp_data_out = rdata;
	// Embedded operation keeps running when deselected
	assign busy_out = rb_sync;
endmodule : pfb_host
`default_nettype wire

// [test/pfb_host_chk.sv]
// Checker for the host flash pin sequencing
`timescale 1ns/1ps
`default_nettype none
module pfb_host_chk
	import pfb_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic req_valid_in,
	input wire logic req_ready_out,
	input wire pfb_pkg::pfb_op_t req_op_in,
	input wire logic rsp_valid_out,
	input wire logic busy_out,
	input wire logic [pfb_pkg::ADDR_W-1:0] address_pins_out,
	input wire logic data_pins_oe_out,
	input wire logic chip_sel_n_out,
	input wire logic out_en_n_out,
	input wire logic wr_en_n_out,
	input wire logic flash_rst_n_out,
	input wire logic high_id_voltage_out,
	input wire logic ready_busy_n_in
);
	// =====================================
	// Assertions
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);
	logic tk;
	assign tk = req_valid_in && req_ready_out;
	a_rdwr_exclusive: assert property (out_en_n_out || wr_en_n_out)
		else $error("read and write strobes overlap");
	a_read_strobes: assert property (!out_en_n_out |->
		!chip_sel_n_out && wr_en_n_out) else $error("bad read levels");
	a_write_strobes: assert property (!wr_en_n_out && !high_id_voltage_out |->
		!chip_sel_n_out && out_en_n_out && data_pins_oe_out)
		else $error("bad write levels");
	a_drive_off_read: assert property (data_pins_oe_out |-> out_en_n_out)
		else $error("host drives during read");
	a_prot_levels: assert property (high_id_voltage_out |->
		address_pins_out[1] && !address_pins_out[0] && !chip_sel_n_out
		&& out_en_n_out) else $error("bad protect levels");
	a_read_latency: assert property (tk && req_op_in == PFB_OP_READ |=>
		##1 !out_en_n_out ##[2:4] rsp_valid_out) else $error("read late");
	a_reset_width: assert property (tk && req_op_in == PFB_OP_RESET |=>
		##1 (!flash_rst_n_out)[*8]) else $error("reset pulse short");
	a_rsp_single: assert property (rsp_valid_out |=> !rsp_valid_out)
		else $error("response not a pulse");
	a_busy_follow: assert property ($fell(ready_busy_n_in) |->
		##[1:3] busy_out) else $error("busy not seen");
	c_read: cover property (tk && req_op_in == PFB_OP_READ);
	c_unprot: cover property (high_id_voltage_out && address_pins_out[6]);
	c_busy_read: cover property (busy_out && rsp_valid_out);
endmodule : pfb_host_chk
bind pfb_host pfb_host_chk u_pfb_host_chk (
	.clk_in, .nrst_in, .req_valid_in, .req_ready_out, .req_op_in,
	.rsp_valid_out, .busy_out, .address_pins_out, .data_pins_oe_out,
	.chip_sel_n_out, .out_en_n_out, .wr_en_n_out, .flash_rst_n_out,
	.high_id_voltage_out, .ready_busy_n_in
);
`default_nettype wire

// [test/pfb_flash_mdl.sv]
// Behavioural flash device on the far side of the host controller
`timescale 1ns/1ps
`default_nettype none
module pfb_flash_mdl
	import pfb_pkg::*;
#(
	parameter logic [7:0] STAT = 8'h80
) (
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] host_dq_in,
	input wire logic host_oe_in,
	input wire logic cs_n_in,
	input wire logic oe_n_in,
	input wire logic we_n_in,
	input wire logic rst_n_in,
	input wire logic busy_in,
	output logic [DATA_W-1:0] dq_out,
	output logic ready_busy_n_out
);
	logic [DATA_W-1:0] val;
	logic [DATA_W-1:0] last;
	logic drv;
	logic wr_act;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	int wr_cnt = 0;
	assign drv = !cs_n_in && !oe_n_in && we_n_in && rst_n_in;
	// Array pattern at once after reset, status while busy
	assign val = busy_in ? STAT : addr_in[7:0] ^ 8'hA5;
	always @* if (drv) last = val;
	// Released lines show the inverse of the last byte
	assign dq_out = host_oe_in ? host_dq_in : (drv ? val : ~last);
	assign ready_busy_n_out = !busy_in;
	// Unaddressed command latches, taken once as the write strobe ends
	assign wr_act = !cs_n_in && !we_n_in && oe_n_in && rst_n_in;
	always @(negedge wr_act) begin
		wr_addr <= addr_in;
		wr_data <= host_dq_in;
		wr_cnt <= wr_cnt + 1;
	end
endmodule : pfb_flash_mdl
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the host flash controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pfb_pkg::*;
	localparam logic [7:0] STAT = 8'h80;
	logic clk, nrst, rv, rdy, rspv, bsy, oe, cs_n, oe_n, we_n, frst_n, hv;
	logic rb_n, bsy_req;
	pfb_op_t op;
	logic [ADDR_W-1:0] a, ad;
	logic [DATA_W-1:0] d, rd, dq, dout;
	int n_fail, check_count, c0;
	pfb_host u_pfb_host (.clk_in(clk), .nrst_in(nrst), .req_valid_in(rv),
		.req_ready_out(rdy), .req_op_in(op), .req_addr_in(a),
		.req_data_in(d), .rsp_valid_out(rspv), .rsp_data_out(rd),
		.busy_out(bsy), .address_pins_out(ad), .data_pins_in(dq),
		.data_pins_out(dout), .data_pins_oe_out(oe), .chip_sel_n_out(cs_n),
		.out_en_n_out(oe_n), .wr_en_n_out(we_n), .flash_rst_n_out(frst_n),
		.high_id_voltage_out(hv), .ready_busy_n_in(rb_n));
	pfb_flash_mdl #(.STAT(STAT)) u_pfb_flash_mdl (.addr_in(ad),
		.host_dq_in(dout), .host_oe_in(oe), .cs_n_in(cs_n), .oe_n_in(oe_n),
		.we_n_in(we_n), .rst_n_in(frst_n), .busy_in(bsy_req), .dq_out(dq),
		.ready_busy_n_out(rb_n));
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic complete_run;
		$display("checks=%0d fails=%0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task automatic idle;
		int i = 0;
		do @(negedge clk); while (rdy !== 1'b1 && ++i < 4000);
		if (i >= 4000) begin
			n_fail++;
			complete_run();
		end
	endtask : idle
	task automatic issue(input pfb_op_t o, input logic [20:0] x,
		input logic [7:0] y);
		idle();
		@(posedge clk);
		rv <= 1'b1;
		op <= o;
		a <= x;
		d <= y;
		@(posedge clk);
		rv <= 1'b0;
	endtask : issue
	task automatic t_read(input logic [20:0] x, input logic [7:0] e);
		int i = 0;
		issue(PFB_OP_READ, x, 8'h00);
		do @(negedge clk); while (rspv !== 1'b1 && ++i < 10);
		if (i >= 10) begin
			n_fail++;
			complete_run();
		end
		chk(rd, e);
	endtask : t_read
	task automatic t_prog(input int n);
		c0 = u_pfb_flash_mdl.wr_cnt;
		for (int k = 0; k < n; k++) issue(PFB_OP_WRITE, 21'h00_0555, 8'h3C + k);
		idle();
		chk(u_pfb_flash_mdl.wr_cnt - c0, n);
		chk(u_pfb_flash_mdl.wr_data, 8'h3C + n - 1);
		t_read(21'h00_0555, 8'h55 ^ 8'hA5);
	endtask : t_prog
	task automatic t_busy;
		@(posedge clk);
		bsy_req <= 1'b1;
		repeat (4) @(negedge clk);
		chk(bsy, 1'b1);
		t_read(21'h00_0001, STAT);
		@(posedge clk);
		bsy_req <= 1'b0;
		repeat (4) @(negedge clk);
		chk(bsy, 1'b0);
	endtask : t_busy
	task automatic t_prot(input logic p);
		issue(p ? PFB_OP_UNPROTECT : PFB_OP_PROTECT, 21'h1F_0000, 8'h00);
		repeat (10) @(negedge clk);
		chk({hv, we_n, cs_n, oe_n}, 4'b1001);
		chk({ad[20:16], ad[6], ad[1:0]}, {5'h1F, p, 2'b10});
		idle();
	endtask : t_prot
	task automatic t_rst;
		issue(PFB_OP_RESET, 21'h00_0000, 8'h00);
		repeat (3) @(negedge clk);
		chk(frst_n, 1'b0);
		t_read(21'h00_00F0, 8'hF0 ^ 8'hA5);
	endtask : t_rst
	initial begin
		nrst = 1'b0;
		rv = 1'b0;
		op = PFB_OP_READ;
		a = '0;
		d = '0;
		bsy_req = 1'b0;
		n_fail = 0;
		check_count = 0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		t_read(21'h1F_FFFF, 8'hFF ^ 8'hA5);
		t_prog(4);
		t_prog(2);
		t_busy();
		t_prot(1'b0);
		t_prot(1'b1);
		t_rst();
		complete_run();
	end
endmodule : testbench
`default_nettype wire
